// File: src/abu_cmp.sv
`timescale 1ns/1ns
// Address comparator; purely combinational so an opcode hit lands in the fetch cycle.
module abu_cmp
    import abu_pkg::*;
(
    // Compared address and break address.
    input wire logic [15:0] cpu_addr_i,
    input wire logic [15:0] brk_addr_i,
    // Qualifiers.
    input wire logic enable_i,
    input wire logic valid_i,
    input wire logic low_power_i,
    input wire logic lock_i,
    // Result.
    output logic hit_o
);

    // Full sixteen bit compare, blocked in standby and after a hit.
    always_comb begin
        hit_o = 1'b0;
        if (enable_i && valid_i && !low_power_i && !lock_i) begin // RQ10 RQ17 RQ12
            hit_o = (cpu_addr_i == brk_addr_i); // RQ1
        end
    end

endmodule

// File: src/abu_pkg.sv
// Notes on behaviour
// RQ1 - Enabled address match raises a breakpoint request.
// RQ2 - Break makes core insert a software interrupt.
// RQ3 - Vector is FFFC normally, FEFC in monitor.
// RQ4 - Software writing active flag one forces break.
// RQ5 - Software break taken before the next instruction.
// RQ6 - Opcode match: instruction waits for break routine.
// RQ7 - Operand match: instruction completes, then break.
// RQ8 - Return from interrupt ends the break state.
// RQ9 - Active flag: hardware sets, zero write clears.
// RQ10 - Enable bit seven, read/write, reset clears.
// RQ11 - Break address in high/low byte registers.
// RQ12 - Same address never refires until address rewritten.
// RQ13 - Other flags clearable in break only if enabled.
// RQ14 - Timer counter halted while break is active.
// RQ15 - Watchdog held off in monitor break if set.
// RQ16 - Flag shows wait mode left through a break.
// RQ17 - No address match break in wait or stop.
// RQ18 - Registers are byte wide, single cycle access.
package abu_pkg;

    // Register bus geometry.
    localparam int ABU_AW = 4;
    localparam int ABU_DW = 8;

    // Register offsets on the plain register port.
    localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_ADDRESS_HIGH = 4'h1;
    localparam logic [3:0] OFS_ADDRESS_LOW = 4'h2;
    localparam logic [3:0] OFS_AUXILIARY = 4'h3;
    localparam logic [3:0] OFS_BREAK_STATUS = 4'h4;
    localparam logic [3:0] OFS_FLAG_CONTROL = 4'h5;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h7;

    // Field positions.
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_WDOG_OFF = 0;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_CLEAR_EN = 7;
    localparam int BIT_IRQ_ENTRY = 0;
    localparam int BIT_IRQ_EXIT = 1;

    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // Break vectors.
    localparam logic [15:0] VEC_NORMAL = 16'hFFFC;
    localparam logic [15:0] VEC_MONITOR = 16'hFEFC;

    // Break state of the core.
    typedef enum logic [0:0] {
        ABU_RUN = 1'b0,
        ABU_BRK = 1'b1
    } abu_state_t;

    // Status arriving from the core and integration logic.
    typedef struct packed {
        logic [15:0] addr;
        logic fetch;
        logic operand;
        logic return_from_interrupt_instruction;
        logic wait_md;
        logic stop_md;
        logic monitor;
        logic emul;
    } abu_cpu_t;

    // Controls leaving towards the core and other modules.
    typedef struct packed {
        logic breakpoint_request;
        logic swi_inject;
        logic break_state;
        logic timer_halt;
        logic watchdog_off;
        logic clear_allow;
    } abu_sys_t;

endpackage

// File: src/abu_top.sv
`timescale 1ns/1ns
// Break unit: compares program addresses and steers the core into a break.
module abu_top
    import abu_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Register port.
    input wire logic [ABU_AW-1:0] addr_i,
    input wire logic [ABU_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ABU_DW-1:0] rdata_o,
    // Core side.
    input wire abu_cpu_t cpu_i,
    output abu_sys_t sys_o,
    output logic [15:0] vector_addr_o,
    // Interrupt.
    output logic irq_o
);

    // Select helper shared by the register decodes except the read data mux.
    function automatic logic sel(input logic [3:0] a, input logic [3:0] ofs);
        sel = (a == ofs);
    endfunction

    // Register contents.
    logic enable_ff; // Break enable.
    logic active_ff; // Break active flag.
    logic [7:0] addr_hi_ff; // Break address high byte.
    logic [7:0] addr_lo_ff; // Break address low byte.
    logic wdog_off_ff; // Watchdog off in monitor break.
    logic wait_exit_ff; // Wait left through a break.
    logic clear_en_ff; // Flag clears allowed in break.
    logic [1:0] irq_st_ff; // Sticky event bits.
    logic [1:0] irq_mask_ff; // Event mask.
    logic [7:0] rdata_ff; // Read data register.
    logic [15:0] vec_ff; // Vector towards the core.

    // Internal control.
    abu_state_t state_ff; // Run or break.
    logic pend_ff; // Break waiting for the next instruction boundary.
    logic lock_ff; // Blocks refire on the same address.
    logic hit; // Address match this cycle.
    logic req; // Breakpoint request this cycle.
    logic sw_set; // Software writes one to the active flag.
    logic wr_ctl; // Write to the status and control register.
    logic wr_adr; // Write to either address byte.
    logic rti_exit; // Return instruction leaves the break.
    logic [1:0] irq_ev; // Events of this cycle.

    // Write decodes.
    assign wr_ctl = wr_i && sel(addr_i, OFS_STATUS_CONTROL); // RQ18
    assign wr_adr = wr_i && (sel(addr_i, OFS_ADDRESS_HIGH) || sel(addr_i, OFS_ADDRESS_LOW));
    assign sw_set = wr_ctl && wdata_i[BIT_ACTIVE];

    // Comparator on the program address.
    abu_cmp u_cmp (
        .cpu_addr_i(cpu_i.addr),
        .brk_addr_i({addr_hi_ff, addr_lo_ff}),
        .enable_i(enable_ff),
        .valid_i(cpu_i.fetch || cpu_i.operand),
        .low_power_i(cpu_i.wait_md || cpu_i.stop_md),
        .lock_i(lock_ff),
        .hit_o(hit)
    );

    // An opcode hit breaks in the fetch cycle so the opcode runs only after the break; an
    // operand hit or software break waits for the next fetch boundary.
    assign req = (hit && cpu_i.fetch) || (pend_ff && cpu_i.fetch); // RQ6 RQ5 RQ7
    assign rti_exit = (state_ff == ABU_BRK) && cpu_i.return_from_interrupt_instruction && !req;

    // Outputs to the core and neighbouring modules.
    always_comb begin
        sys_o.breakpoint_request = req; // RQ1
        sys_o.swi_inject = req; // RQ2
        sys_o.break_state = (state_ff == ABU_BRK);
        sys_o.timer_halt = (state_ff == ABU_BRK); // RQ14
        sys_o.watchdog_off = (state_ff == ABU_BRK) && cpu_i.monitor && wdog_off_ff; // RQ15
        sys_o.clear_allow = (state_ff != ABU_BRK) || clear_en_ff; // RQ13
    end

    assign vector_addr_o = vec_ff;
    assign rdata_o = rdata_ff;

    // Vector follows the monitor mode one cycle late; it is resampled every cycle.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vec_ff <= VEC_NORMAL;
        end else begin
            vec_ff <= cpu_i.monitor ? VEC_MONITOR : VEC_NORMAL; // RQ3
        end
    end

    // Break enable bit.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            enable_ff <= 1'b0; // RQ10
        end else if (wr_ctl) begin
            enable_ff <= wdata_i[BIT_ENABLE]; // RQ10
        end
    end

    // Active flag; a hardware set wins over a zero write in the same cycle.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            active_ff <= 1'b0; // RQ9
        end else if (hit || sw_set) begin
            active_ff <= 1'b1; // RQ9 RQ4
        end else if (wr_ctl) begin
            active_ff <= 1'b0; // RQ9
        end
    end

    // Break address bytes.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_hi_ff <= RST_BYTE; // RQ11
            addr_lo_ff <= RST_BYTE; // RQ11
        end else if (wr_i) begin
            if (sel(addr_i, OFS_ADDRESS_HIGH)) begin
                addr_hi_ff <= wdata_i; // RQ11
            end
            if (sel(addr_i, OFS_ADDRESS_LOW)) begin
                addr_lo_ff <= wdata_i; // RQ11
            end
        end
    end

    // Refire lock: set by a hit, released only by a write to either address byte, so that
    // clearing the flag alone cannot retrigger on the routine's return.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_ff <= 1'b0;
        end else if (hit) begin
            lock_ff <= 1'b1; // RQ12
        end else if (wr_adr) begin
            lock_ff <= 1'b0; // RQ12
        end
    end

    // Pending break for operand hits and software requests.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_ff <= 1'b0;
        end else if (req) begin
            pend_ff <= 1'b0;
        end else if ((hit && !cpu_i.fetch) || sw_set) begin
            pend_ff <= 1'b1; // RQ7 RQ4
        end
    end

    // Break state of the core: entered on a request, left on return.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= ABU_RUN;
        end else begin
            case (state_ff)
                ABU_RUN: begin
                    if (req) begin
                        state_ff <= ABU_BRK;
                    end
                end
                ABU_BRK: begin
                    if (rti_exit) begin
                        state_ff <= ABU_RUN; // RQ8
                    end
                end
                default: begin
                    state_ff <= ABU_RUN;
                end
            endcase
        end
    end

    // Auxiliary and flag control bits.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdog_off_ff <= 1'b0; // RQ15
            clear_en_ff <= 1'b0;
        end else if (wr_i) begin
            if (sel(addr_i, OFS_AUXILIARY)) begin
                wdog_off_ff <= wdata_i[BIT_WDOG_OFF]; // RQ15
            end
            if (sel(addr_i, OFS_FLAG_CONTROL)) begin
                clear_en_ff <= wdata_i[BIT_CLEAR_EN]; // RQ13
            end
        end
    end

    // Wait exit flag; only meaningful in emulation. Writing one is ignored,
    // and a new set wins over a zero write.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_exit_ff <= 1'b0;
        end else if (req && cpu_i.wait_md && cpu_i.emul) begin
            wait_exit_ff <= 1'b1; // RQ16
        end else if (wr_i && sel(addr_i, OFS_BREAK_STATUS) && !wdata_i[BIT_WAIT_EXIT]) begin
            wait_exit_ff <= 1'b0; // RQ16
        end
    end

    // Event bits; a read clears them but an event in that cycle survives.
    assign irq_ev = {rti_exit, req};
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_st_ff <= RST_IRQ;
        end else if (rd_i && sel(addr_i, OFS_IRQ_STATUS)) begin
            irq_st_ff <= irq_ev;
        end else begin
            irq_st_ff <= irq_st_ff | irq_ev;
        end
    end

    // Interrupt mask.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_mask_ff <= RST_IRQ;
        end else if (wr_i && sel(addr_i, OFS_IRQ_MASK)) begin
            irq_mask_ff <= wdata_i[1:0];
        end
    end

    assign irq_o = |(irq_st_ff & irq_mask_ff);

    // Read data one cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= RST_BYTE;
        end else if (rd_i) begin
            case (addr_i) // RQ18
                OFS_STATUS_CONTROL: rdata_ff <= {enable_ff, active_ff, 6'h00};
                OFS_ADDRESS_HIGH: rdata_ff <= addr_hi_ff;
                OFS_ADDRESS_LOW: rdata_ff <= addr_lo_ff;
                OFS_AUXILIARY: rdata_ff <= {7'h00, wdog_off_ff};
                OFS_BREAK_STATUS: rdata_ff <= {6'h00, wait_exit_ff, 1'h0};
                OFS_FLAG_CONTROL: rdata_ff <= {clear_en_ff, 7'h00};
                OFS_IRQ_STATUS: rdata_ff <= {6'h00, irq_st_ff};
                OFS_IRQ_MASK: rdata_ff <= {6'h00, irq_mask_ff};
                default: rdata_ff <= RST_BYTE;
            endcase
        end else begin
            rdata_ff <= RST_BYTE;
        end
    end

    // Checks on the unit's own signals.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // Entry: request, then break state the next cycle.
    sequence s_entry;
        req ##1 (state_ff == ABU_BRK);
    endsequence

    // Exit: return seen inside the break with no new request.
    sequence s_exit;
        (state_ff == ABU_BRK) && cpu_i.return_from_interrupt_instruction && !req;
    endsequence

    AST_OPCODE_HIT: assert property (hit && cpu_i.fetch |-> s_entry) // RQ6
        else $error("Opcode hit did not enter break.");
    AST_REQ_OUT: assert property (hit && cpu_i.fetch |-> sys_o.breakpoint_request
        && sys_o.swi_inject) // RQ1
        else $error("Hit without request.");
    AST_VECTOR: assert property ($stable(cpu_i.monitor) && req |->
        vector_addr_o == (cpu_i.monitor ? VEC_MONITOR : VEC_NORMAL)) // RQ3
        else $error("Wrong break vector.");
    AST_SW_BREAK: assert property (sw_set && !req ##1 cpu_i.fetch |-> req) // RQ4
        else $error("Software break not taken at next fetch.");
    AST_OPERAND: assert property (hit && !cpu_i.fetch && !req |=> pend_ff && !req
        || cpu_i.fetch) // RQ7
        else $error("Operand hit broke early.");
    AST_PEND_FIRE: assert property (pend_ff && cpu_i.fetch |-> req) // RQ5
        else $error("Pending break not taken at boundary.");
    AST_RTI_EXIT: assert property (s_exit |=> state_ff == ABU_RUN) // RQ8
        else $error("Return did not leave break.");
    AST_ACTIVE_SET: assert property (hit |=> active_ff) // RQ9
        else $error("Active flag not set by hit.");
    AST_NO_REFIRE: assert property (hit && !wr_adr |=> !hit) // RQ12
        else $error("Same address fired twice.");
    AST_DISABLED: assert property (!enable_ff |-> !hit) // RQ10
        else $error("Hit while disabled.");
    AST_LOW_POWER: assert property (cpu_i.wait_md || cpu_i.stop_md |-> !hit) // RQ17
        else $error("Hit in standby.");
    AST_CLEAR_GATE: assert property (state_ff == ABU_BRK && !clear_en_ff |->
        !sys_o.clear_allow) // RQ13
        else $error("Flag clear allowed in break.");
    AST_TIMER: assert property (s_entry |-> ##1 sys_o.timer_halt) // RQ14
        else $error("Timer not halted in break.");
    AST_WDOG: assert property (sys_o.watchdog_off |-> cpu_i.monitor && wdog_off_ff
        && state_ff == ABU_BRK) // RQ15
        else $error("Watchdog off outside monitor break.");

endmodule

// File: test/abu_core_model.sv
`timescale 1ns/1ns
// Core stand-in: runs a loop of two-byte instructions and obeys break requests.
module abu_core_model
    import abu_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Bench controls: return request and mode levels {wait, stop, monitor, emul}.
    input wire logic ret_i,
    input wire logic [3:0] mode_i,
    // Unit side.
    input wire abu_sys_t sys_i,
    input wire logic [15:0] vector_i,
    output abu_cpu_t cpu_o
);
    logic [15:0] pc_ff; // Opcode address of the current instruction.
    logic opnd_ff; // High in the operand half of an instruction.
    logic brk_ff; // High while the break routine runs.
    logic rti_ff; // Return pulse at the end of the break routine.

    // One driver for the whole struct, so no field has two sources.
    always_comb begin
        cpu_o.addr = brk_ff ? vector_i : pc_ff + {15'h0000, opnd_ff};
        cpu_o.fetch = !brk_ff && !opnd_ff;
        cpu_o.operand = !brk_ff && opnd_ff;
        cpu_o.return_from_interrupt_instruction = rti_ff;
        {cpu_o.wait_md, cpu_o.stop_md, cpu_o.monitor, cpu_o.emul} = mode_i;
    end

    // The program counter stays put on a break, so the broken instruction runs after exit.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_ff <= 16'h0100;
            opnd_ff <= 1'b0;
            brk_ff <= 1'b0;
            rti_ff <= 1'b0;
        end else if (brk_ff) begin
            // The break stays one more cycle so the return pulse never meets a fetch.
            rti_ff <= ret_i && !rti_ff;
            if (rti_ff) begin
                brk_ff <= 1'b0;
            end
        end else if (sys_i.swi_inject && !opnd_ff) begin
            brk_ff <= 1'b1;
        end else if (mode_i[3:2] == 2'b00) begin
            // In wait or stop the bus freezes where it stood.
            opnd_ff <= !opnd_ff;
            if (opnd_ff) begin
                pc_ff <= 16'h0100 | ((pc_ff + 16'h0002) & 16'h001F);
            end
        end
    end
endmodule

// File: test/test_abu_top.sv
`timescale 1ns/1ns
// Bench for the break unit; register traffic plus a core stand-in running a loop.
module test_abu_top
    import abu_pkg::*;
;
    logic mclk_i = 1'b0; // Bus clock.
    logic rstn_i = 1'b0; // Reset, active low.
    logic [ABU_AW-1:0] addr_i = '0;
    logic [ABU_DW-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [ABU_DW-1:0] rdata_o;
    abu_cpu_t cpu_i;
    abu_sys_t sys_o;
    logic [15:0] vector_addr_o;
    logic irq_o;
    logic ret = 1'b0; // Asks the core to leave its break routine.
    logic [3:0] mode = 4'h0; // Core modes {wait, stop, monitor, emul}.
    int fails = 0;
    int cmp_count = 0;
    int req_cnt = 0; // Break requests seen so far.
    logic [15:0] req_addr = 16'h0000; // Bus address at the last request.

    abu_top u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_i(cpu_i), .sys_o(sys_o),
        .vector_addr_o(vector_addr_o), .irq_o(irq_o));
    abu_core_model u_core (.mclk_i(mclk_i), .rstn_i(rstn_i), .ret_i(ret), .mode_i(mode),
        .sys_i(sys_o), .vector_i(vector_addr_o), .cpu_o(cpu_i));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    // Logs each request; the injected instruction must go with it.
    always @(posedge mclk_i) begin
        if (sys_o.breakpoint_request === 1'b1) begin
            req_cnt <= req_cnt + 1;
            req_addr <= cpu_i.addr;
            chk("swi_inject", 16'h0001, {15'h0000, sys_o.swi_inject});
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compares one value; unknown bits never match.
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        // Let the landing edge settle so a caller may compare right after.
        #1;
    endtask

    // One-cycle read; data stand only in the following cycle.
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk($sformatf("register %0d", a), {8'h00, e}, {8'h00, rdata_o});
    endtask

    // Bounded wait for a new request; running out ends the run.
    task automatic wait_req(input int n);
        int c0;
        c0 = req_cnt;
        repeat (n) begin
            @(posedge mclk_i);
            #1;
            if (req_cnt != c0) begin
                return;
            end
        end
        fails++;
        $display("[ERR] breakpoint_request expected 1 seen 0");
        wrap_up();
    endtask

    // Checks that no request appears for n cycles.
    task automatic no_req(input int n);
        int c0;
        c0 = req_cnt;
        repeat (n) @(posedge mclk_i);
        #1;
        chk("request count", c0[15:0], req_cnt[15:0]);
    endtask

    // Writes the control byte, then returns from the break routine.
    task automatic leave(input logic [7:0] ctl);
        wr(OFS_STATUS_CONTROL, ctl);
        @(posedge mclk_i);
        ret <= 1'b1;
        @(posedge mclk_i);
        ret <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("break_state", 16'h0000, {15'h0000, sys_o.break_state});
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'b1;
        // Reset values, offset 8 being unmapped.
        for (int a = 0; a < 9; a++) begin
            rchk(a[3:0], 8'h00);
        end
        wr(OFS_ADDRESS_HIGH, 8'hA5);
        wr(OFS_ADDRESS_LOW, 8'h5A);
        wr(OFS_AUXILIARY, 8'h01);
        wr(OFS_FLAG_CONTROL, 8'h80);
        wr(4'hA, 8'hFF);
        rchk(OFS_ADDRESS_HIGH, 8'hA5);
        rchk(OFS_ADDRESS_LOW, 8'h5A);
        rchk(OFS_AUXILIARY, 8'h01);
        rchk(OFS_FLAG_CONTROL, 8'h80);
        rchk(4'hA, 8'h00);
        // A matching opcode address while disabled must stay quiet.
        wr(OFS_ADDRESS_HIGH, 8'h01);
        wr(OFS_ADDRESS_LOW, 8'h04);
        wr(OFS_FLAG_CONTROL, 8'h00);
        no_req(40);
        // Opcode hit with the interrupt still masked.
        wr(OFS_STATUS_CONTROL, 8'h80);
        wait_req(40);
        chk("request address", 16'h0104, req_addr);
        repeat (2) @(posedge mclk_i);
        #1;
        chk("break_state", 16'h0001, {15'h0000, sys_o.break_state});
        chk("timer_halt", 16'h0001, {15'h0000, sys_o.timer_halt});
        chk("clear_allow", 16'h0000, {15'h0000, sys_o.clear_allow});
        chk("watchdog_off", 16'h0000, {15'h0000, sys_o.watchdog_off});
        chk("vector", VEC_NORMAL, vector_addr_o);
        chk("irq masked", 16'h0000, {15'h0000, irq_o});
        rchk(OFS_STATUS_CONTROL, 8'hC0);
        wr(OFS_FLAG_CONTROL, 8'h80);
        chk("clear_allow", 16'h0001, {15'h0000, sys_o.clear_allow});
        wr(OFS_IRQ_MASK, 8'h01);
        chk("irq raised", 16'h0001, {15'h0000, irq_o});
        rchk(OFS_IRQ_STATUS, 8'h01);
        chk("irq cleared", 16'h0000, {15'h0000, irq_o});
        // Clearing the flag without a new address: no second break on it.
        leave(8'h80);
        rchk(OFS_STATUS_CONTROL, 8'h80);
        rchk(OFS_IRQ_STATUS, 8'h02);
        no_req(80);
        // Rewriting the address allows the same break again.
        wr(OFS_ADDRESS_LOW, 8'h04);
        wait_req(40);
        chk("request address", 16'h0104, req_addr);
        leave(8'h80);
        rchk(OFS_IRQ_STATUS, 8'h03);
        // Operand hit: break taken at the following opcode fetch.
        wr(OFS_ADDRESS_LOW, 8'h05);
        wait_req(40);
        chk("request address", 16'h0106, req_addr);
        leave(8'h80);
        // Software break in monitor mode while disabled.
        wr(OFS_STATUS_CONTROL, 8'h00);
        @(posedge mclk_i);
        mode <= 4'h2;
        wr(OFS_STATUS_CONTROL, 8'h40);
        wait_req(5);
        chk("request on opcode", 16'h0000, {15'h0000, req_addr[0]});
        repeat (2) @(posedge mclk_i);
        #1;
        chk("vector", VEC_MONITOR, vector_addr_o);
        chk("watchdog_off", 16'h0001, {15'h0000, sys_o.watchdog_off});
        leave(8'h00);
        // Wait mode: a frozen matching bus must not break; leaving wait does.
        // Enter wait, with emulation on, as an operand cycle ends, so the bus freezes on a fetch.
        repeat (4) begin
            @(posedge mclk_i);
            if (cpu_i.operand) begin
                break;
            end
        end
        mode <= 4'h9;
        repeat (2) @(posedge mclk_i);
        wr(OFS_ADDRESS_HIGH, cpu_i.addr[15:8]);
        wr(OFS_ADDRESS_LOW, cpu_i.addr[7:0]);
        wr(OFS_STATUS_CONTROL, 8'h80);
        no_req(20);
        // A software break taken in wait must raise the wait exit flag.
        wr(OFS_STATUS_CONTROL, 8'hC0);
        wait_req(5);
        rchk(OFS_BREAK_STATUS, 8'h02);
        leave(8'h80);
        wr(OFS_BREAK_STATUS, 8'h00);
        rchk(OFS_BREAK_STATUS, 8'h00);
        @(posedge mclk_i);
        mode <= 4'h0;
        wait_req(5);
        leave(8'h80);
        wrap_up();
    end
endmodule
